// ==== verilog/ctotr_regs.sv ====
// Core timing and offset trim register bank
`timescale 1ns/1ps
`include "ctotr_cfg.svh"

// Operation
// - Timing trims are 8-bit read/write sample adjusts
// - Timing trim chosen per core, mode, phase
// - Reset loads factory trims, software may overwrite
// - Offset trims hold 12-bit unsigned low bits
// - First core on input A uses A trim
// - First core on input B uses B trim
module ctotr_regs #(
  parameter logic [`CTOTR_TRIM_BYTES*`CTOTR_DATA_W-1:0] FACTORY_TRIM = `CTOTR_FACTORY_TRIM
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire ctotr_pkg::ctotr_addr_t reg_addr_in,
  input wire ctotr_pkg::ctotr_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output ctotr_pkg::ctotr_byte_t reg_rdata_out,
  input wire logic dual_channel_mode_in,
  input wire logic subst_for_second_in,
  input wire logic first_core_on_second_input_in,
  input wire logic subst_core_on_first_input_in,
  input wire logic foreground_cal_running_in,
  input wire logic background_calibration_enable_in,
  input wire logic background_offset_calibration_enable_in,
  input wire logic offset_calibration_enable_in,
  input wire logic foreground_calibration_complete_in,
  input wire logic calibration_halted_flag_in,
  output logic trim_loading_out,
  output ctotr_pkg::ctotr_byte_t second_core_timing_out,
  output logic second_core_timing_valid_out,
  output ctotr_pkg::ctotr_byte_t subst_core_timing_out,
  output logic subst_core_timing_valid_out,
  output ctotr_pkg::ctotr_offset_t first_core_offset_out,
  output logic first_core_offset_valid_out,
  output ctotr_pkg::ctotr_offset_t subst_core_offset_out,
  output logic subst_core_offset_valid_out
);
  import ctotr_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic bank_hit(input ctotr_addr_t addr);
    bank_hit = (addr & `CTOTR_BANK_MASK) == `CTOTR_BANK_BASE;
  endfunction : bank_hit

  // Upper byte of an offset trim keeps only four bits
  function automatic ctotr_byte_t field_mask(input logic [`CTOTR_IDX_W-1:0] idx,
                                             input ctotr_byte_t data);
    if (idx[0] && (idx != `CTOTR_IDX_SECOND_TIMING)) begin
      field_mask = data & `CTOTR_OFS_HI_MASK;
    end else begin
      field_mask = data & `CTOTR_FULL_MASK;
    end
  endfunction : field_mask

  function automatic ctotr_offset_t join_offset(input ctotr_byte_t hi, input ctotr_byte_t lo);
    join_offset = {hi[3:0], lo};
  endfunction : join_offset

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  ctotr_state_e state_r;
  logic [`CTOTR_IDX_W-1:0] rom_addr_r;
  logic load_valid_r;
  logic [`CTOTR_IDX_W-1:0] load_idx_r;
  ctotr_byte_t rom_data;
  logic rom_rd_en;
  ctotr_byte_t trim_r [`CTOTR_TRIM_BYTES];
  logic locked_wr_r;
  logic running;
  logic wr_bank;
  logic wr_status;
  logic offset_locked;
  ctotr_byte_t status_word;
  ctotr_byte_t subst_core_for_second_timing_trim;
  ctotr_byte_t second_core_dual_timing_trim;
  ctotr_offset_t first_core_input_a_offset_trim;
  ctotr_offset_t first_core_input_b_offset_trim;
  ctotr_offset_t subst_core_input_a_offset_trim;

  assign running = (state_r == CTOTR_RUN);
  assign rom_rd_en = (state_r == CTOTR_LOAD);
  assign wr_bank = reg_wr_in && running && bank_hit(reg_addr_in);
  assign wr_status = reg_wr_in && (reg_addr_in == `CTOTR_ADDR_CAL_STATUS);
  assign offset_locked = foreground_cal_running_in ||
                         (background_calibration_enable_in &&
                          background_offset_calibration_enable_in);

  assign subst_core_for_second_timing_trim = trim_r[`CTOTR_IDX_SUBST_TIMING];
  assign second_core_dual_timing_trim = trim_r[`CTOTR_IDX_SECOND_TIMING];
  assign first_core_input_a_offset_trim =
    join_offset(trim_r[`CTOTR_IDX_FIRST_INA_LO + 3'h1], trim_r[`CTOTR_IDX_FIRST_INA_LO]);
  assign first_core_input_b_offset_trim =
    join_offset(trim_r[`CTOTR_IDX_FIRST_INB_LO + 3'h1], trim_r[`CTOTR_IDX_FIRST_INB_LO]);
  assign subst_core_input_a_offset_trim =
    join_offset(trim_r[`CTOTR_IDX_SUBST_INA_LO + 3'h1], trim_r[`CTOTR_IDX_SUBST_INA_LO]);

  // ------------------------------------------------------------
  // Factory trim load after reset
  // ------------------------------------------------------------
  ctotr_trim_rom #(
    .DEPTH(`CTOTR_TRIM_BYTES),
    .WIDTH(`CTOTR_DATA_W),
    .CONTENTS(FACTORY_TRIM)
  ) u_trim_rom (
    .clk_in(clk_in),
    .rd_en_in(rom_rd_en),
    .rd_addr_in(rom_addr_r),
    .rd_data_out(rom_data)
  );

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= CTOTR_LOAD;
      rom_addr_r <= '0;
    end else begin
      unique case (state_r)
        CTOTR_LOAD: begin
          rom_addr_r <= rom_addr_r + 3'h1;
          if (rom_addr_r == `CTOTR_IDX_LAST) begin
            state_r <= CTOTR_DRAIN;
          end
        end
        CTOTR_DRAIN: begin
          state_r <= CTOTR_RUN;
        end
        CTOTR_RUN: begin
          state_r <= CTOTR_RUN;
        end
        default: begin
          state_r <= CTOTR_LOAD;
        end
      endcase
    end
  end

  // ROM answers one cycle late, so index travels beside it
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      load_valid_r <= 1'b0;
      load_idx_r <= '0;
    end else begin
      load_valid_r <= rom_rd_en;
      load_idx_r <= rom_addr_r;
    end
  end

  // ------------------------------------------------------------
  // Trim storage
  // ------------------------------------------------------------
  // Bus writes are ignored until the factory load has finished
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < `CTOTR_TRIM_BYTES; i++) begin
      if (srst_in) begin
        trim_r[i] <= `CTOTR_BYTE_RESET;
      end else if (load_valid_r && (load_idx_r == i[`CTOTR_IDX_W-1:0])) begin
        trim_r[i] <= field_mask(load_idx_r, rom_data);
      end else if (wr_bank && (reg_addr_in[`CTOTR_IDX_W-1:0] == i[`CTOTR_IDX_W-1:0])) begin
        trim_r[i] <= field_mask(reg_addr_in[`CTOTR_IDX_W-1:0], reg_wdata_in);
      end
    end
  end

  // ------------------------------------------------------------
  // Locked write monitor
  // ------------------------------------------------------------
  // Device does not block such writes; it only records them
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      locked_wr_r <= 1'b0;
    end else if (wr_bank && offset_locked &&
                 (reg_addr_in[`CTOTR_IDX_W-1:0] >= `CTOTR_IDX_FIRST_INA_LO)) begin
      locked_wr_r <= 1'b1;
    end else if (wr_status && reg_wdata_in[`CTOTR_ST_LOCKED_WR]) begin
      locked_wr_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[`CTOTR_ST_LOADING] = !running;
    status_word[`CTOTR_ST_FG_RUNNING] = foreground_cal_running_in;
    status_word[`CTOTR_ST_BG_EN] = background_calibration_enable_in;
    status_word[`CTOTR_ST_BG_OS_EN] = background_offset_calibration_enable_in;
    status_word[`CTOTR_ST_OS_EN] = offset_calibration_enable_in;
    status_word[`CTOTR_ST_FOREGROUND_CALIBRATION_COMPLETE] = foreground_calibration_complete_in;
    status_word[`CTOTR_ST_HALTED] = calibration_halted_flag_in;
    status_word[`CTOTR_ST_LOCKED_WR] = locked_wr_r;
  end

  // Data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in && running && bank_hit(reg_addr_in)) begin
      reg_rdata_out <= trim_r[reg_addr_in[`CTOTR_IDX_W-1:0]];
    end else if (reg_rd_in && (reg_addr_in == `CTOTR_ADDR_CAL_STATUS)) begin
      reg_rdata_out <= status_word;
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // ------------------------------------------------------------
  // Trim outputs to the cores
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      trim_loading_out <= 1'b1;
    end else begin
      trim_loading_out <= !running;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      second_core_timing_out <= `CTOTR_BYTE_RESET;
      second_core_timing_valid_out <= 1'b0;
      subst_core_timing_out <= `CTOTR_BYTE_RESET;
      subst_core_timing_valid_out <= 1'b0;
    end else begin
      second_core_timing_valid_out <= running && dual_channel_mode_in;
      second_core_timing_out <= dual_channel_mode_in ?
                                second_core_dual_timing_trim : `CTOTR_BYTE_RESET;
      subst_core_timing_valid_out <= running && dual_channel_mode_in &&
                                     subst_for_second_in;
      subst_core_timing_out <= (dual_channel_mode_in && subst_for_second_in) ?
                               subst_core_for_second_timing_trim : `CTOTR_BYTE_RESET;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      first_core_offset_out <= `CTOTR_OFS_RESET;
      first_core_offset_valid_out <= 1'b0;
      subst_core_offset_out <= `CTOTR_OFS_RESET;
      subst_core_offset_valid_out <= 1'b0;
    end else begin
      first_core_offset_valid_out <= running;
      if (first_core_on_second_input_in) begin
        first_core_offset_out <= first_core_input_b_offset_trim;
      end else begin
        first_core_offset_out <= first_core_input_a_offset_trim;
      end
      subst_core_offset_valid_out <= running && subst_core_on_first_input_in;
      subst_core_offset_out <= subst_core_on_first_input_in ?
                               subst_core_input_a_offset_trim : `CTOTR_OFS_RESET;
    end
  end

endmodule : ctotr_regs

// ==== verilog/ctotr_cfg.svh ====
// Offsets, field layouts and counts of the core timing and offset trim bank
`ifndef CTOTR_CFG_SVH
`define CTOTR_CFG_SVH

// ------------------------------------------------------------
// Bus widths
// ------------------------------------------------------------
`define CTOTR_ADDR_W 12
`define CTOTR_DATA_W 8
`define CTOTR_OFS_W 12

// ------------------------------------------------------------
// Byte addresses
// ------------------------------------------------------------
`define CTOTR_ADDR_SUBST_TIMING 12'h088
`define CTOTR_ADDR_SECOND_TIMING 12'h089
`define CTOTR_ADDR_FIRST_INA_OFS 12'h08A
`define CTOTR_ADDR_FIRST_INB_OFS 12'h08C
`define CTOTR_ADDR_SUBST_INA_OFS 12'h08E
`define CTOTR_ADDR_CAL_STATUS 12'h0F0
`define CTOTR_BANK_BASE 12'h088
`define CTOTR_BANK_MASK 12'hFF8

// ------------------------------------------------------------
// Byte indices inside the trim bank
// ------------------------------------------------------------
`define CTOTR_TRIM_BYTES 8
`define CTOTR_IDX_W 3
`define CTOTR_IDX_SUBST_TIMING 3'h0
`define CTOTR_IDX_SECOND_TIMING 3'h1
`define CTOTR_IDX_FIRST_INA_LO 3'h2
`define CTOTR_IDX_FIRST_INB_LO 3'h4
`define CTOTR_IDX_SUBST_INA_LO 3'h6
`define CTOTR_IDX_LAST 3'h7

// ------------------------------------------------------------
// Field layouts and reset values
// ------------------------------------------------------------
`define CTOTR_OFS_HI_MASK 8'h0F
`define CTOTR_FULL_MASK 8'hFF
`define CTOTR_BYTE_RESET 8'h00
`define CTOTR_OFS_RESET 12'h000
`define CTOTR_FACTORY_TRIM 64'h0805_0A07_0C03_4080

// ------------------------------------------------------------
// Status register bit positions
// ------------------------------------------------------------
`define CTOTR_ST_LOADING 0
`define CTOTR_ST_FG_RUNNING 1
`define CTOTR_ST_BG_EN 2
`define CTOTR_ST_BG_OS_EN 3
`define CTOTR_ST_OS_EN 4
`define CTOTR_ST_FOREGROUND_CALIBRATION_COMPLETE 5
`define CTOTR_ST_HALTED 6
`define CTOTR_ST_LOCKED_WR 7

`endif

// ==== verilog/ctotr_pkg.sv ====
// Types shared by the core timing and offset trim bank
package ctotr_pkg;

  typedef logic [7:0] ctotr_byte_t;
  typedef logic [11:0] ctotr_offset_t;
  typedef logic [11:0] ctotr_addr_t;

  typedef enum logic [1:0] {
    CTOTR_LOAD = 2'b00,
    CTOTR_DRAIN = 2'b01,
    CTOTR_RUN = 2'b10
  } ctotr_state_e;

endpackage : ctotr_pkg

// ==== verilog/ctotr_trim_rom.sv ====
// Factory trim store with registered read data
`timescale 1ns/1ps

module ctotr_trim_rom #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter logic [DEPTH*WIDTH-1:0] CONTENTS = '0
) (
  input wire logic clk_in,
  input wire logic rd_en_in,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Contents fixed at build time, stands in for fuses
  always_ff @(posedge clk_in) begin
    if (rd_en_in) begin
      rd_data_out <= CONTENTS[rd_addr_in*WIDTH +: WIDTH];
    end
  end

endmodule : ctotr_trim_rom

// ==== verification/ctotr_regs_chk.sv ====
// Assertion checker for the core timing and offset trim bank
`timescale 1ns/1ps

module ctotr_regs_chk (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire ctotr_pkg::ctotr_addr_t reg_addr_in,
  input wire ctotr_pkg::ctotr_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire ctotr_pkg::ctotr_byte_t reg_rdata_out,
  input wire logic dual_channel_mode_in,
  input wire logic subst_for_second_in,
  input wire logic trim_loading_out,
  input wire ctotr_pkg::ctotr_byte_t second_core_timing_out,
  input wire logic second_core_timing_valid_out,
  input wire logic subst_core_timing_valid_out,
  input wire logic first_core_offset_valid_out,
  input wire logic subst_core_offset_valid_out
);
  import ctotr_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_odd_nibble: assert property ((reg_rd_in && (reg_addr_in == 12'h08B ||
    reg_addr_in == 12'h08D || reg_addr_in == 12'h08F)) |=> reg_rdata_out[7:4] == 4'h0)
    else $error("reserved offset bits read nonzero");
  chk_timing_write: assert property ((reg_wr_in && reg_addr_in == 12'h089 &&
    !trim_loading_out && dual_channel_mode_in) ##1 (dual_channel_mode_in &&
    !(reg_wr_in && reg_addr_in == 12'h089)) |=> second_core_timing_out == $past(reg_wdata_in, 2))
    else $error("written timing trim not applied");
  chk_timing_idle: assert property (!$past(dual_channel_mode_in) |->
    second_core_timing_out == 8'h00)
    else $error("second core timing driven outside dual mode");
  chk_second_valid: assert property (second_core_timing_valid_out |->
    $past(dual_channel_mode_in))
    else $error("second core timing valid without dual mode");
  chk_subst_valid: assert property (subst_core_timing_valid_out |->
    $past(dual_channel_mode_in && subst_for_second_in))
    else $error("substitute timing valid without its phase");
  chk_load_quiet: assert property (trim_loading_out |-> !(first_core_offset_valid_out ||
    second_core_timing_valid_out || subst_core_timing_valid_out || subst_core_offset_valid_out))
    else $error("core output valid while trims load");
  chk_load_length: assert property ($fell(srst_in) |-> trim_loading_out [*8] ##[1:4]
    !trim_loading_out)
    else $error("factory trim load length wrong");
endmodule : ctotr_regs_chk

bind ctotr_regs ctotr_regs_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .dual_channel_mode_in(dual_channel_mode_in), .subst_for_second_in(subst_for_second_in),
  .trim_loading_out(trim_loading_out), .second_core_timing_out(second_core_timing_out),
  .second_core_timing_valid_out(second_core_timing_valid_out),
  .subst_core_timing_valid_out(subst_core_timing_valid_out),
  .first_core_offset_valid_out(first_core_offset_valid_out),
  .subst_core_offset_valid_out(subst_core_offset_valid_out));

// ==== verification/tb.sv ====
// Self-checking testbench for the core timing and offset trim bank
`timescale 1ns/1ps
`include "ctotr_cfg.svh"

module tb;
  import ctotr_pkg::*;
  typedef struct packed {
    ctotr_addr_t addr;
    ctotr_byte_t wdata;
    ctotr_byte_t rexp;
  } ctotr_row_s;
  localparam logic [63:0] FAC = `CTOTR_FACTORY_TRIM;
  // Odd offset bytes keep only the low nibble; 0x090 is unmapped
  ctotr_row_s rows [9] = '{'{12'h088, 8'hA5, 8'hA5}, '{12'h089, 8'h5A, 8'h5A},
    '{12'h08A, 8'h34, 8'h34}, '{12'h08B, 8'hFF, 8'h0F}, '{12'h08C, 8'h78, 8'h78},
    '{12'h08D, 8'hF6, 8'h06}, '{12'h08E, 8'hBC, 8'hBC}, '{12'h08F, 8'h3D, 8'h0D},
    '{12'h090, 8'h77, 8'h00}};
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  ctotr_addr_t reg_addr_in = 12'h000;
  ctotr_byte_t reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [9:0] lvl_r = 10'h000;
  ctotr_byte_t reg_rdata_out, second_core_timing_out, subst_core_timing_out;
  ctotr_offset_t first_core_offset_out, subst_core_offset_out;
  logic trim_loading_out, second_core_timing_valid_out, subst_core_timing_valid_out;
  logic first_core_offset_valid_out, subst_core_offset_valid_out;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  always #2.5 clk_in = ~clk_in;

  ctotr_regs DUT (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .dual_channel_mode_in(lvl_r[0]),
    .subst_for_second_in(lvl_r[1]), .first_core_on_second_input_in(lvl_r[2]),
    .subst_core_on_first_input_in(lvl_r[3]), .foreground_cal_running_in(lvl_r[4]),
    .background_calibration_enable_in(lvl_r[5]),
    .background_offset_calibration_enable_in(lvl_r[6]),
    .offset_calibration_enable_in(lvl_r[7]), .foreground_calibration_complete_in(lvl_r[8]),
    .calibration_halted_flag_in(lvl_r[9]), .trim_loading_out(trim_loading_out),
    .second_core_timing_out(second_core_timing_out),
    .second_core_timing_valid_out(second_core_timing_valid_out),
    .subst_core_timing_out(subst_core_timing_out),
    .subst_core_timing_valid_out(subst_core_timing_valid_out),
    .first_core_offset_out(first_core_offset_out),
    .first_core_offset_valid_out(first_core_offset_valid_out),
    .subst_core_offset_out(subst_core_offset_out),
    .subst_core_offset_valid_out(subst_core_offset_valid_out));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input ctotr_addr_t a, input ctotr_byte_t d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Answer stands one cycle only, so the cycle after must read zero
  task automatic rd(input ctotr_addr_t a, input ctotr_byte_t e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, e);
    @(posedge clk_in);
    #1;
    chk(reg_rdata_out, 8'h00);
  endtask : rd

  task automatic setl(input logic [9:0] v);
    @(posedge clk_in);
    lvl_r <= v;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : setl

  task automatic wait_load();
    int n;
    n = 0;
    while (trim_loading_out !== 1'b0 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    @(posedge clk_in);
  endtask : wait_load

  task automatic final_report();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    #1;
    chk(trim_loading_out, 1'b1);
    @(posedge clk_in);
    srst_in <= 1'b0;
    wait_load();
    for (int i = 0; i < 8; i++) begin
      rd(`CTOTR_BANK_BASE + ctotr_addr_t'(i),
         FAC[8*i +: 8] & ((i % 2 == 1 && i > 1) ? 8'h0F : 8'hFF));
    end
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
    end
    setl(10'h00B);
    chk(second_core_timing_out, 8'h5A);
    chk(subst_core_timing_out, 8'hA5);
    chk({trim_loading_out, second_core_timing_valid_out, subst_core_timing_valid_out,
         subst_core_offset_valid_out, first_core_offset_valid_out}, 5'h0F);
    chk(first_core_offset_out, 12'hF34);
    chk(subst_core_offset_out, 12'hDBC);
    wr(12'h089, 8'hC3);
    @(posedge clk_in);
    #1;
    chk(second_core_timing_out, 8'hC3);
    setl(10'h004);
    chk(first_core_offset_out, 12'h678);
    chk({second_core_timing_out, subst_core_timing_valid_out}, 9'h000);
    // Offset reads under two calibration states; neither state gates the reads
    setl(10'h180);
    rd(12'h0F0, 8'h30);
    rd(12'h08C, 8'h78);
    setl(10'h260);
    rd(12'h0F0, 8'h4C);
    rd(12'h08A, 8'h34);
    setl(10'h000);
    // Read straight after write, no idle cycle
    @(posedge clk_in);
    reg_addr_in <= 12'h08E;
    reg_wdata_in <= 8'h5C;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, 8'h5C);
    // Second reset; a write during the load must be dropped
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    // Byte 0 is already loaded when this write lands
    @(posedge clk_in);
    wr(12'h088, 8'h11);
    rd(12'h0F0, 8'h01);
    rd(12'h088, 8'h00);
    wait_load();
    rd(12'h088, FAC[7:0]);
    rd(12'h08E, FAC[55:48]);
    final_report();
  end
endmodule : tb
